//--- peir_pkg.sv
// Constants, types and carrier definitions for the endpoint interrupt request block.
// Assumes a single core clock of 250 MHz and an Avalon-MM register master.
// Function
// - Only one mode; MSI beats legacy.
// - Shared request port, mode chosen automatically.
// - MSI-X accepted anytime on separate interface.
// - Legacy request sends assert message.
// - Grant only after message handed over.
// - INTx line fixed by build parameter.
// - Deassert sends deassert message, second grant.
// - MSI enabled: request makes one MSI.
// - MSI message carries five-bit vector index.
// - MSI detected on rising request edge.
// - Vector count output is power-of-two code.
// - External MSI-X present only when built.
package peir_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0]  PEIR_ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  PEIR_ADDR_STATUS   = 4'h4;
  localparam logic [3:0]  PEIR_ADDR_MSICFG   = 4'h8;
  localparam logic [3:0]  PEIR_ADDR_COUNT    = 4'hc;
  localparam int          PEIR_CTRL_LEG_BIT  = 0;
  localparam int          PEIR_CTRL_MSI_BIT  = 1;
  localparam int          PEIR_CTRL_MSIX_BIT = 2;
  localparam logic [2:0]  PEIR_CTRL_RESET    = 3'h0;
  localparam logic [2:0]  PEIR_WIDTH_RESET   = 3'h0;
  localparam logic [2:0]  PEIR_WIDTH_MAX     = 3'h5;
  localparam logic [31:0] PEIR_UNMAPPED_DATA = 32'h0000_0000;

  // ****************************************************************
  // Message encodings and message count reset
  // ****************************************************************
  localparam logic [1:0]  PEIR_MSG_NONE      = 2'h0;
  localparam logic [1:0]  PEIR_MSG_INTX_SET  = 2'h1;
  localparam logic [1:0]  PEIR_MSG_INTX_CLR  = 2'h2;
  localparam logic [1:0]  PEIR_MSG_MSI       = 2'h3;
  localparam logic [15:0] PEIR_COUNT_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    PEIR_MODE_OFF = 2'b00,
    PEIR_MODE_LEG = 2'b01,
    PEIR_MODE_MSI = 2'b10
  } peir_mode_e;

endpackage : peir_pkg

//--- peir_msg_if.sv
// Carrier between the request engine and the link-side message sender.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface peir_msg_if;
  logic       valid;
  logic       ready;
  logic [1:0] kind;
  logic [4:0] vector;

  modport src
  (
    output valid,
    output kind,
    output vector,
    input  ready
  );
  modport snk
  (
    input  valid,
    input  kind,
    input  vector,
    output ready
  );
endinterface : peir_msg_if

//--- peir_msg_tx.sv
// Hands one interrupt message at a time to the link block and reports handover.
// Assumes the link block answers with a level ready that may stall any time.
`timescale 1ns/1ps
module peir_msg_tx
  import peir_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  peir_msg_if.snk         msg,
  input  wire logic [1:0] line_irq_pin_select,
  output logic            link_valid,
  output logic [1:0]      link_kind,
  output logic [4:0]      link_vector,
  output logic [1:0]      link_pin,
  input  wire logic       link_ready,
  output logic            sent
);

  typedef struct packed {
    logic       busy;
    logic [1:0] kind;
    logic [4:0] vector;
    logic       sent;
  } peir_tx_s;

  peir_tx_s st;
  peir_tx_s next_st;

  always_comb
  begin
    next_st      = st;
    next_st.sent = 1'b0;
    if (!st.busy && msg.valid)
    begin
      next_st.busy   = 1'b1;
      next_st.kind   = msg.kind;
      next_st.vector = msg.vector;
    end
    else if (st.busy && link_ready)
    begin
      // Completion is reported only once the link block has taken the message.
      next_st.busy = 1'b0;
      next_st.sent = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign msg.ready   = !st.busy;
  assign link_valid  = st.busy;
  assign link_kind   = st.kind;
  assign link_vector = st.vector;
  assign link_pin    = line_irq_pin_select;
  assign sent        = st.sent;

endmodule : peir_msg_tx

//--- peir_msix_gate.sv
// Optional pass-through of the external MSI-X request interface.
// Assumes the vector table and pending array live in user logic.
`timescale 1ns/1ps
module peir_msix_gate
  import peir_pkg::*;
#(
  parameter bit MSIX_EXTERNAL = 1'b1
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        msix_enable,
  input  wire logic        msix_req,
  input  wire logic [31:0] msix_data,
  input  wire logic [63:0] msix_addr,
  output logic             msix_link_req,
  output logic [31:0]      msix_link_data,
  output logic [63:0]      msix_link_addr,
  input  wire logic        msix_link_done,
  output logic             msix_sent
);

  typedef struct packed {
    logic        req;
    logic [31:0] data;
    logic [63:0] addr;
    logic        sent;
  } peir_mx_s;

  peir_mx_s st;
  peir_mx_s next_st;

  always_comb
  begin
    next_st      = st;
    next_st.sent = 1'b0;
    // Independent of legacy and MSI state, so it is accepted at any time.
    if (!st.req && msix_req && msix_enable && MSIX_EXTERNAL)
    begin
      next_st.req  = 1'b1;
      next_st.data = msix_data;
      next_st.addr = msix_addr;
    end
    else if (st.req && msix_link_done)
    begin
      next_st.req  = 1'b0;
      next_st.sent = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign msix_link_req  = st.req;
  assign msix_link_data = st.data;
  assign msix_link_addr = st.addr;
  assign msix_sent      = st.sent;

endmodule : peir_msix_gate

//--- peir_top.sv
// Endpoint interrupt request engine: legacy INTx and MSI over one request/grant port.
// Assumes request inputs come from user logic on core_clk; registers on Avalon-MM.
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module peir_top
  import peir_pkg::*;
#(
  parameter logic [1:0] INT_PIN       = 2'h0,
  parameter bit         MSIX_EXTERNAL = 1'b1
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Shared legacy/MSI request port.
  input  wire logic        irq_request,
  input  wire logic [4:0]  msi_vector_index,
  output logic             irq_grant,
  output logic [2:0]       msi_vector_count,
  // Link-side message port.
  output logic             link_valid,
  output logic [1:0]       link_kind,
  output logic [4:0]       link_vector,
  output logic [1:0]       link_pin,
  input  wire logic        link_ready,
  // External MSI-X.
  input  wire logic        msix_req,
  input  wire logic [31:0] msix_data,
  input  wire logic [63:0] msix_addr,
  output logic             msix_link_req,
  output logic [31:0]      msix_link_data,
  output logic [63:0]      msix_link_addr,
  input  wire logic        msix_link_done,
  output logic             msix_sent
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    PEIR_ST_IDLE     = 3'b000,
    PEIR_ST_SET_WAIT = 3'b001,
    PEIR_ST_HELD     = 3'b010,
    PEIR_ST_CLR_WAIT = 3'b011,
    PEIR_ST_MSI_WAIT = 3'b100
  } peir_state_e;

  typedef struct packed {
    peir_state_e fsm;
    logic [2:0]  enables;
    logic [2:0]  width;
    logic        req_d;
    logic        issue;
    logic [1:0]  kind;
    logic [4:0]  vector;
    logic [15:0] msg_count;
    logic        rd_ack;
    logic [31:0] rdata;
  } peir_top_s;

  peir_top_s  st;
  peir_top_s  next_st;
  peir_mode_e mode;
  logic       sent;

  peir_msg_if msg ();

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic peir_mode_e pick_mode(input logic [2:0] en);
    if (en[PEIR_CTRL_MSI_BIT])
      pick_mode = PEIR_MODE_MSI;
    else if (en[PEIR_CTRL_LEG_BIT])
      pick_mode = PEIR_MODE_LEG;
    else
      pick_mode = PEIR_MODE_OFF;
  endfunction : pick_mode

  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge_be[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
  endfunction : merge_be

  // No user select input: the mode follows only what the host enabled.
  assign mode = pick_mode(st.enables);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [31:0] wv;
    wv          = 32'h0000_0000;
    next_st     = st;
    next_st.rd_ack = 1'b0;
    next_st.req_d  = irq_request;
    if (msg.ready && st.issue)
      next_st.issue = 1'b0;

    case (st.fsm)
      PEIR_ST_IDLE:
      begin
        if (mode == PEIR_MODE_MSI && irq_request && !st.req_d)
        begin
          next_st.issue  = 1'b1;
          next_st.kind   = PEIR_MSG_MSI;
          next_st.vector = msi_vector_index;
          next_st.fsm    = PEIR_ST_MSI_WAIT;
        end
        else if (mode == PEIR_MODE_LEG && irq_request)
        begin
          next_st.issue  = 1'b1;
          next_st.kind   = PEIR_MSG_INTX_SET;
          next_st.vector = 5'h00;
          next_st.fsm    = PEIR_ST_SET_WAIT;
        end
        // With no mode enabled the request is simply not looked at.
      end
      PEIR_ST_SET_WAIT:
        if (sent)
          next_st.fsm = PEIR_ST_HELD;
      PEIR_ST_HELD:
        // Deassert is always sent, even if the host changed mode meanwhile.
        if (!irq_request)
        begin
          next_st.issue = 1'b1;
          next_st.kind  = PEIR_MSG_INTX_CLR;
          next_st.fsm   = PEIR_ST_CLR_WAIT;
        end
      PEIR_ST_CLR_WAIT:
        if (sent)
          next_st.fsm = PEIR_ST_IDLE;
      PEIR_ST_MSI_WAIT:
        if (sent)
          next_st.fsm = PEIR_ST_IDLE;
      default:
        next_st.fsm = PEIR_ST_IDLE;
    endcase

    if (sent)
      next_st.msg_count = 16'(st.msg_count + 16'h0001);

    // Registers answer in the cycle after the request, so waitrequest is high one cycle.
    // A write lands only at the edge where waitrequest is low, so a master that waits sees it once.
    if (avs_write && !st.rd_ack)
      next_st.rd_ack = 1'b1;
    else if (avs_write && st.rd_ack)
    begin
      if (avs_address == PEIR_ADDR_CTRL)
      begin
        wv = merge_be({29'h0, st.enables}, avs_writedata, avs_byteenable);
        next_st.enables = wv[2:0];
      end
      else if (avs_address == PEIR_ADDR_MSICFG)
      begin
        wv = merge_be({29'h0, st.width}, avs_writedata, avs_byteenable);
        next_st.width = (wv[2:0] > PEIR_WIDTH_MAX) ? PEIR_WIDTH_MAX : wv[2:0];
      end
    end
    else if (avs_read && !st.rd_ack)
    begin
      if (avs_address == PEIR_ADDR_CTRL)
        next_st.rdata = {29'h0, st.enables};
      else if (avs_address == PEIR_ADDR_STATUS)
        next_st.rdata = {27'h0, mode, st.fsm};
      else if (avs_address == PEIR_ADDR_MSICFG)
        next_st.rdata = {29'h0, st.width};
      else if (avs_address == PEIR_ADDR_COUNT)
        next_st.rdata = {16'h0, st.msg_count};
      else
        next_st.rdata = PEIR_UNMAPPED_DATA;
      next_st.rd_ack = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st         <= '0;
      st.fsm     <= PEIR_ST_IDLE;
      st.enables <= PEIR_CTRL_RESET;
      st.width   <= PEIR_WIDTH_RESET;
      st.msg_count <= PEIR_COUNT_RESET;
    end
    else if (clk_en)
      st <= next_st;
  end

  // ****************************************************************
  // Submodules and outputs
  // ****************************************************************
  assign msg.valid  = st.issue;
  assign msg.kind   = st.kind;
  assign msg.vector = st.vector;

  peir_msg_tx u_tx
  (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .clk_en              (clk_en),
    .msg                 (msg),
    .line_irq_pin_select (INT_PIN),
    .link_valid          (link_valid),
    .link_kind           (link_kind),
    .link_vector         (link_vector),
    .link_pin            (link_pin),
    .link_ready          (link_ready),
    .sent                (sent)
  );

  peir_msix_gate #(.MSIX_EXTERNAL(MSIX_EXTERNAL)) u_msix
  (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .clk_en         (clk_en),
    .msix_enable    (st.enables[PEIR_CTRL_MSIX_BIT]),
    .msix_req       (msix_req),
    .msix_data      (msix_data),
    .msix_addr      (msix_addr),
    .msix_link_req  (msix_link_req),
    .msix_link_data (msix_link_data),
    .msix_link_addr (msix_link_addr),
    .msix_link_done (msix_link_done),
    .msix_sent      (msix_sent)
  );

  // The grant is the one-cycle handover pulse, one per message sent.
  assign irq_grant        = sent;
  assign msi_vector_count = st.width;
  assign avs_readdata     = st.rdata;
  assign avs_waitrequest  = (avs_read || avs_write) && !st.rd_ack;

endmodule : peir_top

//--- peir_top_assertions.sv
// Port checker for the endpoint interrupt request engine, bound into peir_top.
// Assumes clk_en high and host enables written through the CTRL register.
`timescale 1ns/1ps
module peir_top_assertions
  import peir_pkg::*;
#(
  parameter logic [1:0] INT_PIN = 2'h0
)
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        irq_request,
  input wire logic [4:0]  msi_vector_index,
  input wire logic        irq_grant,
  input wire logic [2:0]  msi_vector_count,
  input wire logic        link_valid,
  input wire logic [1:0]  link_kind,
  input wire logic [4:0]  link_vector,
  input wire logic [1:0]  link_pin,
  input wire logic        link_ready,
  input wire logic        msix_req,
  input wire logic        msix_link_req,
  input wire logic        msix_link_done,
  input wire logic        msix_sent
);
  logic [2:0] ena;
  logic [4:0] vcap;

  // Shadow of the host enables, so mode-dependent checks need no internal probe.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ena <= 3'h0;
    else if (avs_write && !avs_waitrequest && avs_address == PEIR_ADDR_CTRL && avs_byteenable[0])
      ena <= avs_writedata[2:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (ena[1] && $rose(irq_request))
      vcap <= msi_vector_index;
  end

  default clocking cb @(posedge core_clk); endclocking
  // A frozen core takes no requests, so checks pause with the clock enable.
  default disable iff (!rst_b || !clk_en);

  sequence s_msi_take;
    ena[1] && $rose(irq_request) && !link_valid;
  endsequence
  sequence s_msi_out;
    link_valid && link_kind == PEIR_MSG_MSI && link_vector == vcap;
  endsequence
  sequence s_all_off;
    (ena[1:0] == 2'h0)[*4];
  endsequence

  property p_pin_fixed;
    link_valid && link_kind != PEIR_MSG_MSI |-> link_pin == INT_PIN;
  endproperty
  property p_grant_pulse;
    irq_grant |=> !irq_grant;
  endproperty
  property p_grant_cause;
    irq_grant |-> $past(link_valid) && $past(link_ready);
  endproperty
  property p_grant_each;
    link_valid && link_ready |=> irq_grant;
  endproperty
  property p_hold;
    link_valid && !link_ready |=> link_valid && $stable(link_kind) && $stable(link_vector);
  endproperty
  property p_msi_one;
    s_msi_take |-> ##[1:4] s_msi_out;
  endproperty
  property p_mode;
    link_valid && ena[1] |-> link_kind == PEIR_MSG_MSI;
  endproperty
  property p_leg_set;
    ena[1:0] == 2'h1 && $rose(irq_request) |-> ##[1:4] (link_valid && link_kind == PEIR_MSG_INTX_SET);
  endproperty
  property p_leg_clr;
    ena[1:0] == 2'h1 && $fell(irq_request) |-> ##[1:8] (link_valid && link_kind == PEIR_MSG_INTX_CLR);
  endproperty
  property p_off;
    s_all_off |-> !link_valid && !irq_grant;
  endproperty
  property p_count;
    msi_vector_count <= PEIR_WIDTH_MAX;
  endproperty
  property p_msix_take;
    ena[2] && msix_req && !msix_link_req |-> ##[1:3] msix_link_req;
  endproperty
  property p_msix_sent;
    msix_link_req && msix_link_done |=> msix_sent;
  endproperty

  a_pin_fixed: assert property (p_pin_fixed) else $error("link pin differs from build pin");
  a_grant_pulse: assert property (p_grant_pulse) else $error("grant longer than one cycle");
  a_grant_cause: assert property (p_grant_cause) else $error("grant without handover");
  a_grant_each: assert property (p_grant_each) else $error("handover without grant");
  a_hold: assert property (p_hold) else $error("message changed while stalled");
  a_msi_one: assert property (p_msi_one) else $error("msi edge gave no message");
  a_mode: assert property (p_mode) else $error("legacy sent while msi enabled");
  a_leg_set: assert property (p_leg_set) else $error("no assert message");
  a_leg_clr: assert property (p_leg_clr) else $error("no deassert message");
  a_off: assert property (p_off) else $error("message with no mode enabled");
  a_count: assert property (p_count) else $error("vector count code out of range");
  a_msix_take: assert property (p_msix_take) else $error("msix request not taken");
  a_msix_sent: assert property (p_msix_sent) else $error("msix done not reported");
endmodule : peir_top_assertions

bind peir_top peir_top_assertions #(.INT_PIN(INT_PIN)) u_chk
(
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .irq_request(irq_request), .msi_vector_index(msi_vector_index), .irq_grant(irq_grant),
  .msi_vector_count(msi_vector_count), .link_valid(link_valid), .link_kind(link_kind),
  .link_vector(link_vector), .link_pin(link_pin), .link_ready(link_ready), .msix_req(msix_req),
  .msix_link_req(msix_link_req), .msix_link_done(msix_link_done), .msix_sent(msix_sent)
);

//--- peir_user_model.sv
// User logic that raises interrupts over the shared request/grant port.
// Assumes it runs on core_clk; grants are one-cycle pulses.
`timescale 1ns/1ps
module peir_user_model
(
  input  wire logic  core_clk,
  input  wire logic  irq_grant,
  output logic       irq_request,
  output logic [4:0] msi_vector_index
);
  initial
  begin
    irq_request = 1'b0;
    msi_vector_index = 5'h00;
  end

  // A lost grant must not hang the run, so every wait is bounded.
  task automatic wait_grant();
    for (int n = 0; n < 60 && irq_grant !== 1'b1; n++)
      @(posedge core_clk);
  endtask : wait_grant

  task automatic legacy_cycle(input int hold);
    @(posedge core_clk);
    irq_request <= 1'b1;
    wait_grant();
    repeat (hold) @(posedge core_clk);
    irq_request <= 1'b0;
    @(posedge core_clk);
    wait_grant();
  endtask : legacy_cycle

  task automatic msi_level(input logic [4:0] v, input int len);
    @(posedge core_clk);
    irq_request <= 1'b1;
    msi_vector_index <= v;
    repeat (len) @(posedge core_clk);
    irq_request <= 1'b0;
    msi_vector_index <= ~v;
    repeat (12) @(posedge core_clk);
  endtask : msi_level
endmodule : peir_user_model

//--- tb_pcie_endpoint_irq_request.sv
// Self-checking bench for peir_top with a user model and a link responder.
// Assumes one 250 MHz clock and an Avalon-MM register master.
`timescale 1ns/1ps
module tb_pcie_endpoint_irq_request;
  import peir_pkg::*;
  localparam logic [1:0] PIN = 2'h2;
  logic        core_clk, rst_b, avs_read, avs_write, avs_waitrequest, irq_request, irq_grant, slow, ce;
  logic        link_valid, link_ready, msix_req, msix_link_req, msix_link_done, msix_sent;
  logic [3:0]  avs_address;
  logic [4:0]  msi_vector_index, link_vector, m_vec;
  logic [2:0]  msi_vector_count;
  logic [1:0]  link_kind, link_pin, m_kind, m_pin;
  logic [31:0] avs_writedata, avs_readdata, msix_data, msix_link_data, mx_data, q;
  logic [63:0] msix_addr, msix_link_addr, mx_addr;
  logic [7:0]  cyc = 8'h00;
  int          err_total, check_count, n_grant, n_sent, g0;

  peir_top #(.INT_PIN(PIN), .MSIX_EXTERNAL(1'b1)) dut
  (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_request(irq_request),
    .msi_vector_index(msi_vector_index), .irq_grant(irq_grant), .msi_vector_count(msi_vector_count),
    .link_valid(link_valid), .link_kind(link_kind), .link_vector(link_vector), .link_pin(link_pin),
    .link_ready(link_ready), .msix_req(msix_req), .msix_data(msix_data), .msix_addr(msix_addr),
    .msix_link_req(msix_link_req), .msix_link_data(msix_link_data), .msix_link_addr(msix_link_addr),
    .msix_link_done(msix_link_done), .msix_sent(msix_sent)
  );

  peir_user_model um
  (
    .core_clk(core_clk), .irq_grant(irq_grant), .irq_request(irq_request),
    .msi_vector_index(msi_vector_index)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Link responder stalls on half the cycles when slow is set.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 8'h01;
    link_ready <= slow ? cyc[1] : 1'b1;
    msix_link_done <= msix_link_req && !msix_link_done && cyc[0];
    if (link_valid && link_ready)
    begin
      m_kind = link_kind;
      m_vec = link_vector;
      m_pin = link_pin;
    end
    if (msix_link_req)
    begin
      mx_data = msix_link_data;
      mx_addr = msix_link_addr;
    end
    n_grant += (irq_grant === 1'b1);
    n_sent += (msix_sent === 1'b1);
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    chk("bus answer", 1, n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    av(0, PEIR_ADDR_CTRL, 0);
    chk("ctrl reset", PEIR_CTRL_RESET, q[2:0]);
    av(0, PEIR_ADDR_STATUS, 0);
    chk("status idle", 32'h0000_0000, q);
    av(0, PEIR_ADDR_MSICFG, 0);
    chk("width reset", PEIR_WIDTH_RESET, q[2:0]);
    av(1, PEIR_ADDR_MSICFG, 32'h7);
    av(0, PEIR_ADDR_MSICFG, 0);
    chk("width clamp", 5, q[2:0]);
    for (int w = 0; w < 6; w++)
    begin
      av(1, PEIR_ADDR_MSICFG, w);
      settle(2);
      chk("vector count", w, msi_vector_count);
    end
    av(1, 4'h2, 32'h5a);
    av(0, 4'h2, 0);
    chk("unmapped", PEIR_UNMAPPED_DATA, q);
  endtask : t_regs

  task automatic t_off();
    av(1, PEIR_ADDR_CTRL, 0);
    g0 = n_grant;
    um.msi_level(5'h03, 1);
    um.msi_level(5'h03, 6);
    chk("grants off", g0, n_grant);
  endtask : t_off

  task automatic t_legacy(input logic s);
    slow <= s;
    av(1, PEIR_ADDR_CTRL, 1);
    g0 = n_grant;
    um.legacy_cycle(10);
    settle(2);
    chk("legacy grants", g0 + 2, n_grant);
    chk("last kind", PEIR_MSG_INTX_CLR, m_kind);
    chk("pin", PIN, m_pin);
  endtask : t_legacy

  task automatic t_msi(input logic [4:0] v, input int len, input logic [2:0] ctl);
    av(1, PEIR_ADDR_CTRL, ctl);
    chk("vector in range", 1, v < (6'h01 << msi_vector_count));
    g0 = n_grant;
    um.msi_level(v, len);
    chk("msi grants", g0 + 1, n_grant);
    chk("msi kind", PEIR_MSG_MSI, m_kind);
    chk("msi vector", v, m_vec);
  endtask : t_msi

  task automatic t_msix();
    av(1, PEIR_ADDR_CTRL, 7);
    g0 = n_sent;
    @(posedge core_clk);
    msix_req <= 1'b1;
    msix_data <= 32'hc0de_0042;
    msix_addr <= 64'hfee0_0000_0000_1230;
    @(posedge core_clk);
    msix_req <= 1'b0;
    settle(20);
    chk("msix sent", g0 + 1, n_sent);
    chk("msix data", 32'hc0de_0042, mx_data);
    chk("msix addr", 64'hfee0_0000_0000_1230, mx_addr);
    // Two legacy pairs and four MSI messages precede this point; MSI-X is not counted.
    av(0, PEIR_ADDR_COUNT, 0);
    chk("msg count", 8, q[15:0]);
  endtask : t_msix

  // A request raised while the clock enable is low must leave no trace once it returns.
  task automatic t_freeze();
    av(1, PEIR_ADDR_CTRL, 2);
    ce <= 1'b0;
    g0 = n_grant;
    um.msi_level(5'h01, 1);
    ce <= 1'b1;
    settle(6);
    chk("frozen grants", g0, n_grant);
  endtask : t_freeze

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial
  begin
    {avs_read, avs_write, msix_req, slow, avs_address, avs_writedata} = '0;
    ce = 1'b1;
    {msix_data, msix_addr} = '0;
    rst_b = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_off();
    t_legacy(1'b0);
    t_legacy(1'b1);
    t_msi(5'h00, 1, 3'h3);
    t_msi(5'h0a, 1, 3'h3);
    t_msi(5'h1f, 1, 3'h2);
    t_msi(5'h11, 20, 3'h2);
    t_freeze();
    t_msix();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
endmodule : tb_pcie_endpoint_irq_request
